// ---- hw/mprb_map.vh ----
// Register codes, field layouts and widths of the motion parameter register bank.
`ifndef MPRB_MAP_VH
`define MPRB_MAP_VH
`define MPRB_CODE_W         8
`define MPRB_CODE_ACCEL     8'h11
`define MPRB_CODE_DECEL     8'h12
`define MPRB_CODE_CHG_DIST  8'h13
`define MPRB_CODE_MOVE_DIST 8'h14
`define MPRB_CODE_POS_OFS   8'h15
`define MPRB_CODE_FLAGS     8'h16
`define MPRB_CODE_CUR_CMD   8'h17
`define MPRB_CODE_AN_GAIN   8'h18
`define MPRB_CODE_IN_CNT    8'h19
`define MPRB_CODE_JOG_VEL   8'h1A
`define MPRB_CODE_RSVD_1    8'h1B
`define MPRB_CODE_RSVD_2    8'h1C
`define MPRB_CODE_MAX_VEL   8'h1D
`define MPRB_CODE_RUN_CUR   8'h1E
`define MPRB_CODE_PEAK_CUR  8'h1F
`define MPRB_CODE_ABS_POS   8'h20
`define MPRB_CODE_RSVD_3    8'h21
`define MPRB_CODE_STEPS_REV 8'h22
`define MPRB_CODE_RUN_RATE  8'h26
// Flag bit positions.
`define MPRB_FLAG_DIST_LIMIT 0
`define MPRB_FLAG_SENSOR     1
`define MPRB_FLAG_LO_OC      2
`define MPRB_FLAG_HI_OC      3
`define MPRB_FLAG_OC_READ    4
`define MPRB_FLAG_OFS_A      5
`define MPRB_FLAG_OFS_B      6
`define MPRB_FLAG_OPEN_A     7
`define MPRB_FLAG_OPEN_B     8
`define MPRB_FLAG_LOGIC_SUP  9
`define MPRB_FLAG_GATE_SUP   10
`define MPRB_FLAG_FL_ERASE   14
`define MPRB_FLAG_FL_SAVE    15
// Flag masks per layout: basic, servo, extended servo, stepper.
`define MPRB_MASK_BASIC      16'h0003
`define MPRB_MASK_SERVO      16'h000F
`define MPRB_MASK_EXT        16'hC07F
`define MPRB_MASK_STEPPER    16'hC7FF
`define MPRB_LAYOUT_BASIC    2'h0
`define MPRB_LAYOUT_SERVO    2'h1
`define MPRB_LAYOUT_EXT      2'h2
`define MPRB_LAYOUT_STEPPER  2'h3
// Integer scale factors between command units and register units.
`define MPRB_RATE_SCALE      6
`define MPRB_VEL_SCALE       240
// Analog gain limits in ADC counts.
`define MPRB_GAIN_MAX        16'sh7FFF
`define MPRB_GAIN_MIN        16'sh8001
`define MPRB_RESET_ZERO      32'h0000_0000
`endif

// ---- hw/mprb_bank.v ----
// Motion parameter register bank with load, read, command-unit writes and event flags.
// Notes on behaviour
// - Every register holds a plain integer, so command values are scaled to whole units.
// - The 16-bit acceleration register stores six times a ramp-up command in rev/s/s.
// - The deceleration register stores six times a ramp-down command in rev/s/s.
// - The jog velocity register stores 240 times a jog speed command in rev/s.
// - The position offset holds encoder position minus the last set-position value, plus any host-loaded adjustment.
// - Flag bit 0x0001 records a distance limit and 0x0002 a sensor found, OR-ed in.
// - Servo layout adds 0x0004 low-side and 0x0008 high-side overcurrent flags.
// - Extended layout adds 0x0010, 0x0020, 0x0040, 0x4000 and 0x8000 fault flags.
// - Stepper layout adds 0x0080, 0x0100, 0x0200 and 0x0400 fault flags.
// - Loading zero into the flag register clears every flag until new events.
// - The analog gain accepts signed values within plus or minus 32767 counts.
// - The velocity register stores 240 times a run rate command in rev/s.
`timescale 1ns/10ps
`include "mprb_map.vh"

module mprb_bank
#(
  parameter FLAG_LAYOUT = 2'h3
)
(
  input  wire        MCLK,
  input  wire        RST_N,
  input  wire        REG_LOAD_STB,
  input  wire [7:0]  REG_CODE,
  input  wire [31:0] REG_WDATA,
  input  wire        CMD_STB,
  input  wire [2:0]  CMD_SEL,
  input  wire [31:0] CMD_VALUE,
  input  wire        SET_POS_STB,
  input  wire [31:0] SET_POS_VALUE,
  input  wire [31:0] ENC_POSITION,
  input  wire [15:0] FLAG_EVENTS,
  output reg  [31:0] REG_RDATA,
  output wire        ZERO_RATE_WARN,
  output wire [15:0] ACCEL_RATE,
  output wire [15:0] DECEL_RATE,
  output wire [15:0] JOG_VEL,
  output wire [15:0] RUN_VEL,
  output wire [15:0] ANALOG_GAIN,
  output wire [31:0] POS_OFFSET,
  output wire [15:0] FLAGS
);

  // ----------------------------------------------------------------
  // Command selectors
  // ----------------------------------------------------------------
  localparam CMD_RAMP_UP   = 3'h0;
  localparam CMD_RAMP_DOWN = 3'h1;
  localparam CMD_JOG_SPEED = 3'h2;
  localparam CMD_RUN_RATE  = 3'h3;
  localparam CMD_CHG_LEN   = 3'h4;
  localparam CMD_MOVE_LEN  = 3'h5;
  localparam CMD_AN_GAIN   = 3'h6;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  reg [15:0] accel_reg;
  reg [15:0] decel_reg;
  reg [31:0] chg_dist_reg;
  reg [31:0] move_dist_reg;
  reg [31:0] set_pos_reg;
  reg [31:0] ofs_adj_reg;
  reg [15:0] flags_reg;
  reg [15:0] cur_cmd_reg;
  reg [15:0] gain_reg;
  reg [31:0] in_cnt_reg;
  reg [15:0] jog_reg;
  reg [15:0] run_vel_reg;
  reg [15:0] max_vel_reg;
  reg [15:0] run_cur_reg;
  reg [15:0] peak_cur_reg;
  reg [31:0] abs_pos_reg;
  reg [15:0] steps_reg;
  reg [15:0] flag_mask;
  reg [15:0] gain_clip;
  reg [15:0] cmd_gain_clip;
  wire [31:0] rate_scaled;
  wire [31:0] vel_scaled;
  wire [31:0] pos_diff;
  wire        ld;

  assign ld = REG_LOAD_STB;

  // Command values arrive in whole command units; multiply into register units.
  assign rate_scaled = CMD_VALUE * `MPRB_RATE_SCALE;
  assign vel_scaled  = CMD_VALUE * `MPRB_VEL_SCALE;

  // Offset is live: encoder minus last set-position, plus any host adjustment.
  assign pos_diff = ENC_POSITION - set_pos_reg + ofs_adj_reg;

  // Flag events outside the selected layout are ignored.
  always @*
  begin
    case (FLAG_LAYOUT)
      `MPRB_LAYOUT_BASIC:   flag_mask = `MPRB_MASK_BASIC;
      `MPRB_LAYOUT_SERVO:   flag_mask = `MPRB_MASK_SERVO;
      `MPRB_LAYOUT_EXT:     flag_mask = `MPRB_MASK_EXT;
      `MPRB_LAYOUT_STEPPER: flag_mask = `MPRB_MASK_STEPPER;
      default:              flag_mask = `MPRB_MASK_BASIC;
    endcase
  end

  // Gain is clamped to the symmetric range so that -32768 never gets stored.
  always @*
  begin
    if ($signed(REG_WDATA) > $signed({{16{1'b0}}, `MPRB_GAIN_MAX}))
      gain_clip = `MPRB_GAIN_MAX;
    else if ($signed(REG_WDATA) < $signed({{16{1'b1}}, `MPRB_GAIN_MIN}))
      gain_clip = `MPRB_GAIN_MIN;
    else
      gain_clip = REG_WDATA[15:0];
  end

  // The gain command goes through the same clamp, so neither path can store -32768.
  always @*
  begin
    if ($signed(CMD_VALUE) > $signed({{16{1'b0}}, `MPRB_GAIN_MAX}))
      cmd_gain_clip = `MPRB_GAIN_MAX;
    else if ($signed(CMD_VALUE) < $signed({{16{1'b1}}, `MPRB_GAIN_MIN}))
      cmd_gain_clip = `MPRB_GAIN_MIN;
    else
      cmd_gain_clip = CMD_VALUE[15:0];
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // A register load takes priority over a command to the same register in the same cycle.
  always @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      accel_reg     <= 16'h0001;
      decel_reg     <= 16'h0001;
      chg_dist_reg  <= `MPRB_RESET_ZERO;
      move_dist_reg <= `MPRB_RESET_ZERO;
      set_pos_reg   <= `MPRB_RESET_ZERO;
      ofs_adj_reg   <= `MPRB_RESET_ZERO;
      cur_cmd_reg   <= 16'h0000;
      gain_reg      <= 16'h0000;
      in_cnt_reg    <= `MPRB_RESET_ZERO;
      jog_reg       <= 16'h0000;
      run_vel_reg   <= 16'h0000;
      max_vel_reg   <= 16'h0000;
      run_cur_reg   <= 16'h0000;
      peak_cur_reg  <= 16'h0000;
      abs_pos_reg   <= `MPRB_RESET_ZERO;
      steps_reg     <= 16'h0000;
    end
    else
    begin
      if (SET_POS_STB)
      begin
        set_pos_reg <= SET_POS_VALUE;
        ofs_adj_reg <= `MPRB_RESET_ZERO;
      end
      if (CMD_STB)
      begin
        case (CMD_SEL)
          CMD_RAMP_UP:   accel_reg     <= rate_scaled[15:0];
          CMD_RAMP_DOWN: decel_reg     <= rate_scaled[15:0];
          CMD_JOG_SPEED: jog_reg       <= vel_scaled[15:0];
          CMD_RUN_RATE:  run_vel_reg   <= vel_scaled[15:0];
          CMD_CHG_LEN:   chg_dist_reg  <= CMD_VALUE;
          CMD_MOVE_LEN:  move_dist_reg <= CMD_VALUE;
          CMD_AN_GAIN:   gain_reg      <= cmd_gain_clip;
          default:       accel_reg     <= accel_reg;
        endcase
      end
      if (ld)
      begin
        // Reserved and unknown codes fall to default and touch nothing.
        case (REG_CODE)
          `MPRB_CODE_ACCEL:     accel_reg     <= REG_WDATA[15:0];
          `MPRB_CODE_DECEL:     decel_reg     <= REG_WDATA[15:0];
          `MPRB_CODE_CHG_DIST:  chg_dist_reg  <= REG_WDATA;
          `MPRB_CODE_MOVE_DIST: move_dist_reg <= REG_WDATA;
          `MPRB_CODE_POS_OFS:   ofs_adj_reg   <= REG_WDATA - (ENC_POSITION - set_pos_reg);
          `MPRB_CODE_CUR_CMD:   cur_cmd_reg   <= REG_WDATA[15:0];
          `MPRB_CODE_AN_GAIN:   gain_reg      <= gain_clip;
          `MPRB_CODE_IN_CNT:    in_cnt_reg    <= REG_WDATA;
          `MPRB_CODE_JOG_VEL:   jog_reg       <= REG_WDATA[15:0];
          `MPRB_CODE_RUN_RATE:  run_vel_reg   <= REG_WDATA[15:0];
          `MPRB_CODE_MAX_VEL:   max_vel_reg   <= REG_WDATA[15:0];
          `MPRB_CODE_RUN_CUR:   run_cur_reg   <= REG_WDATA[15:0];
          `MPRB_CODE_PEAK_CUR:  peak_cur_reg  <= REG_WDATA[15:0];
          `MPRB_CODE_ABS_POS:   abs_pos_reg   <= REG_WDATA;
          `MPRB_CODE_STEPS_REV: steps_reg     <= REG_WDATA[15:0];
          default:              steps_reg     <= steps_reg;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Event flags
  // ----------------------------------------------------------------
  // Sticky flags; an event in the clearing cycle survives because set wins.
  always @(posedge MCLK)
  begin
    if (!RST_N)
      flags_reg <= 16'h0000;
    else if (ld && REG_CODE == `MPRB_CODE_FLAGS)
      flags_reg <= (REG_WDATA[15:0] & flag_mask) | (FLAG_EVENTS & flag_mask);
    else
      flags_reg <= flags_reg | (FLAG_EVENTS & flag_mask);
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Read data is registered one cycle after the code is presented.
  always @(posedge MCLK)
  begin
    if (!RST_N)
      REG_RDATA <= `MPRB_RESET_ZERO;
    else
    begin
      case (REG_CODE)
        `MPRB_CODE_ACCEL:     REG_RDATA <= {16'h0000, accel_reg};
        `MPRB_CODE_DECEL:     REG_RDATA <= {16'h0000, decel_reg};
        `MPRB_CODE_CHG_DIST:  REG_RDATA <= chg_dist_reg;
        `MPRB_CODE_MOVE_DIST: REG_RDATA <= move_dist_reg;
        `MPRB_CODE_POS_OFS:   REG_RDATA <= pos_diff;
        `MPRB_CODE_FLAGS:     REG_RDATA <= {16'h0000, flags_reg};
        `MPRB_CODE_CUR_CMD:   REG_RDATA <= {16'h0000, cur_cmd_reg};
        `MPRB_CODE_AN_GAIN:   REG_RDATA <= {{16{gain_reg[15]}}, gain_reg};
        `MPRB_CODE_IN_CNT:    REG_RDATA <= in_cnt_reg;
        `MPRB_CODE_JOG_VEL:   REG_RDATA <= {16'h0000, jog_reg};
        `MPRB_CODE_RUN_RATE:  REG_RDATA <= {16'h0000, run_vel_reg};
        `MPRB_CODE_MAX_VEL:   REG_RDATA <= {16'h0000, max_vel_reg};
        `MPRB_CODE_RUN_CUR:   REG_RDATA <= {16'h0000, run_cur_reg};
        `MPRB_CODE_PEAK_CUR:  REG_RDATA <= {16'h0000, peak_cur_reg};
        `MPRB_CODE_ABS_POS:   REG_RDATA <= abs_pos_reg;
        `MPRB_CODE_STEPS_REV: REG_RDATA <= {16'h0000, steps_reg};
        default:              REG_RDATA <= `MPRB_RESET_ZERO;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs to the motion logic
  // ----------------------------------------------------------------
  // Zero rates stall the profiler, so a warning level flags it rather than refusing it.
  assign ZERO_RATE_WARN = (accel_reg == 16'h0000) || (decel_reg == 16'h0000);
  assign ACCEL_RATE     = accel_reg;
  assign DECEL_RATE     = decel_reg;
  assign JOG_VEL        = jog_reg;
  assign RUN_VEL        = run_vel_reg;
  assign ANALOG_GAIN    = gain_reg;
  assign POS_OFFSET     = pos_diff;
  assign FLAGS          = flags_reg;

endmodule

// ---- bench/mprb_checker.sv ----
// Port assertions for the motion parameter register bank.
`timescale 1ns/10ps
module mprb_checker
(
  input wire        MCLK,
  input wire        RST_N,
  input wire        REG_LOAD_STB,
  input wire [7:0]  REG_CODE,
  input wire [31:0] REG_WDATA,
  input wire        CMD_STB,
  input wire [2:0]  CMD_SEL,
  input wire [31:0] CMD_VALUE,
  input wire        SET_POS_STB,
  input wire [31:0] SET_POS_VALUE,
  input wire [31:0] ENC_POSITION,
  input wire [15:0] FLAG_EVENTS,
  input wire [31:0] REG_RDATA,
  input wire        ZERO_RATE_WARN,
  input wire [15:0] ACCEL_RATE,
  input wire [15:0] DECEL_RATE,
  input wire [15:0] RUN_VEL,
  input wire [15:0] ANALOG_GAIN,
  input wire [15:0] JOG_VEL,
  input wire [31:0] POS_OFFSET,
  input wire [15:0] FLAGS
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Scaled command values keep only the low half, as the registers do.
  wire [31:0] ramp_full = CMD_VALUE * 32'h6;
  wire [31:0] jog_full  = CMD_VALUE * 32'hF0;
  wire [15:0] ev_m      = FLAG_EVENTS & 16'hC7FF;
  wire        fl_ld     = REG_LOAD_STB && REG_CODE == 8'h16;
  wire        rsv       = REG_CODE == 8'h1B || REG_CODE == 8'h1C || REG_CODE == 8'h21;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  sequence s_clr;
    fl_ld && REG_WDATA == 32'h0 && FLAG_EVENTS == 16'h0;
  endsequence
  sequence s_rsv_wr;
    REG_LOAD_STB && rsv && !CMD_STB && !SET_POS_STB && FLAG_EVENTS == 16'h0;
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_accel_load: assert property (REG_LOAD_STB && REG_CODE == 8'h11 |=>
    ACCEL_RATE == $past(REG_WDATA[15:0])) else $error("Acceleration load lost.");
  a_ramp_cmd: assert property (CMD_STB && CMD_SEL == 3'h0 && !REG_LOAD_STB |=>
    ACCEL_RATE == $past(ramp_full[15:0])) else $error("Ramp command badly scaled.");
  a_decel_cmd: assert property (CMD_STB && CMD_SEL == 3'h1 && !REG_LOAD_STB |=>
    DECEL_RATE == $past(ramp_full[15:0])) else $error("Ramp-down command badly scaled.");
  a_run_cmd: assert property (CMD_STB && CMD_SEL == 3'h3 && !REG_LOAD_STB |=>
    RUN_VEL == $past(jog_full[15:0])) else $error("Run rate command badly scaled.");
  a_gain_range: assert property (ANALOG_GAIN != 16'h8000)
    else $error("Analog gain outside the symmetric range.");
  a_zero_warn: assert property (ZERO_RATE_WARN == (ACCEL_RATE == 16'h0 || DECEL_RATE == 16'h0))
    else $error("Zero rate warning wrong.");
  a_jog_cmd: assert property (CMD_STB && CMD_SEL == 3'h2 && !REG_LOAD_STB |=>
    JOG_VEL == $past(jog_full[15:0])) else $error("Jog command badly scaled.");
  a_offset_set: assert property (SET_POS_STB && !REG_LOAD_STB |=>
    POS_OFFSET == ENC_POSITION - $past(SET_POS_VALUE)) else $error("Offset wrong.");
  a_flag_set: assert property (ev_m != 16'h0 && !fl_ld |=>
    (FLAGS & $past(ev_m)) == $past(ev_m)) else $error("Event flag not set.");
  a_flag_sticky: assert property (!fl_ld |=>
    (FLAGS & $past(FLAGS)) == $past(FLAGS)) else $error("Flag dropped by itself.");
  a_flag_clear: assert property (s_clr |=> FLAGS == 16'h0)
    else $error("Zero load left flags set.");
  a_rsvd_read: assert property (rsv |=> REG_RDATA == 32'h0)
    else $error("Reserved code read nonzero.");
  a_rsvd_write: assert property (s_rsv_wr |=> $stable(ACCEL_RATE) && $stable(FLAGS)
    && $stable(JOG_VEL)) else $error("Reserved write changed a register.");
endmodule
bind mprb_bank mprb_checker u_chk (.*);

// ---- bench/mprb_host.sv ----
// Host model issuing register loads, read selects and command writes.
`timescale 1ns/10ps
module mprb_host
(
  input  wire        MCLK,
  output reg         REG_LOAD_STB = 1'b0,
  output reg  [7:0]  REG_CODE = 8'h11,
  output reg  [31:0] REG_WDATA = 32'h0,
  output reg         CMD_STB = 1'b0,
  output reg  [2:0]  CMD_SEL = 3'h0,
  output reg  [31:0] CMD_VALUE = 32'h0
);
  // A flag clear is a plain zero load on the flag code.
  task load(input [7:0] c, input [31:0] d);
    @(negedge MCLK);
    if ((c == 8'h11 || c == 8'h12) && d == 32'h0) d = 32'h1;
    REG_LOAD_STB = 1'b1;
    REG_CODE = c;
    REG_WDATA = d;
    @(negedge MCLK);
    REG_LOAD_STB = 1'b0;
    REG_WDATA = ~d; // Released data is scrambled so stale values never match.
  endtask
  task cmd(input [2:0] s, input [31:0] v);
    @(negedge MCLK);
    CMD_STB = 1'b1;
    CMD_SEL = s;
    CMD_VALUE = v;
    @(negedge MCLK);
    CMD_STB = 1'b0;
    CMD_VALUE = ~v;
  endtask
  task sel(input [7:0] c);
    @(negedge MCLK);
    REG_CODE = c;
  endtask
endmodule

// ---- bench/mprb_bank_tb_top.sv ----
// Self-checking bench for the motion parameter register bank.
`timescale 1ns/10ps
module mprb_bank_tb_top;
  reg         MCLK = 1'b0;
  reg         RST_N = 1'b0;
  reg         SET_POS_STB = 1'b0;
  reg  [31:0] SET_POS_VALUE = 32'h0;
  reg  [31:0] ENC_POSITION = 32'h0;
  reg  [15:0] FLAG_EVENTS = 16'h0;
  wire        REG_LOAD_STB, CMD_STB;
  wire [7:0]  REG_CODE;
  wire [2:0]  CMD_SEL;
  wire [31:0] REG_WDATA, CMD_VALUE, REG_RDATA;
  reg  [31:0] exp_q[$];
  reg  [31:0] wd[0:17];
  reg  [31:0] exp_now, v, sp;
  reg  [15:0] fl;
  reg  [7:0]  c;
  reg         pend = 1'b0;
  int         err_total = 0, num_checks = 0, cyc = 0, i;
  always #12.5 MCLK = ~MCLK;
  mprb_host h (.MCLK(MCLK), .REG_LOAD_STB(REG_LOAD_STB), .REG_CODE(REG_CODE),
    .REG_WDATA(REG_WDATA), .CMD_STB(CMD_STB), .CMD_SEL(CMD_SEL), .CMD_VALUE(CMD_VALUE));
  mprb_bank DUT (.MCLK(MCLK), .RST_N(RST_N), .REG_LOAD_STB(REG_LOAD_STB), .REG_CODE(REG_CODE),
    .REG_WDATA(REG_WDATA), .CMD_STB(CMD_STB), .CMD_SEL(CMD_SEL), .CMD_VALUE(CMD_VALUE),
    .SET_POS_STB(SET_POS_STB), .SET_POS_VALUE(SET_POS_VALUE), .ENC_POSITION(ENC_POSITION),
    .FLAG_EVENTS(FLAG_EVENTS), .REG_RDATA(REG_RDATA), .ZERO_RATE_WARN(), .ACCEL_RATE(),
    .DECEL_RATE(), .JOG_VEL(), .RUN_VEL(), .ANALOG_GAIN(), .POS_OFFSET(), .FLAGS());
  // Read data trails the code by one edge, so a note is checked one cycle on.
  task rd(input [7:0] code, input [31:0] e);
    h.sel(code);
    exp_q.push_back(e);
    pend <= 1'b1;
    @(negedge MCLK);
    pend <= 1'b0;
  endtask
  function [31:0] exp_of(input [7:0] k, input [31:0] d);
    if (k == 8'h1B || k == 8'h1C || k == 8'h21) exp_of = 32'h0;
    else if (k == 8'h13 || k == 8'h14 || k == 8'h15 || k == 8'h19 || k == 8'h20) exp_of = d;
    else if (k == 8'h16) exp_of = {16'h0, d[15:0] & 16'hC7FF};
    else if (k == 8'h18 && $signed(d) > 32'sh0000_7FFF) exp_of = 32'h0000_7FFF;
    else if (k == 8'h18 && $signed(d) < 32'shFFFF_8001) exp_of = 32'hFFFF_8001;
    else if (k == 8'h18) exp_of = {{16{d[15]}}, d[15:0]};
    else exp_of = {16'h0, d[15:0]};
  endfunction
  // Watcher takes the oldest note whenever a read result is due.
  always @(negedge MCLK)
  begin
    if (pend === 1'b1)
    begin
      num_checks = num_checks + 1;
      exp_now = exp_q.pop_front();
      if (REG_RDATA !== exp_now)
      begin
        err_total = err_total + 1;
        $display("ERROR REG_RDATA code %h expected %h seen %h", REG_CODE, exp_now, REG_RDATA);
      end
    end
  end
  task print_verdict;
    $display("Checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // The run needs under a thousand cycles; a hang is cut well after that.
  always @(posedge MCLK)
  begin
    cyc = cyc + 1;
    if (cyc == 4000)
    begin
      err_total = err_total + 1;
      print_verdict;
    end
  end
  initial
  begin
    void'($urandom(52257));
    repeat (20) @(negedge MCLK);
    RST_N = 1'b1;
    rd(8'h11, 32'h1);
    rd(8'h16, 32'h0);
    $display("Reset value test done");
    for (i = 0; i < 18; i = i + 1)
    begin
      wd[i] = $urandom | 32'h1;
      h.load(8'h11 + i[7:0], wd[i]);
    end
    for (i = 0; i < 18; i = i + 1)
      rd(8'h11 + i[7:0], exp_of(8'h11 + i[7:0], wd[i]));
    h.load(8'h18, 32'hFFFF_8000);
    rd(8'h18, 32'hFFFF_8001);
    $display("Load and read test done");
    for (i = 0; i < 7; i = i + 1)
    begin
      v = $urandom_range(200, 1);
      c = (i == 0) ? 8'h11 : (i == 1) ? 8'h12 : (i == 2) ? 8'h1A : (i == 3) ? 8'h26 : 8'h13;
      if (i > 3) c = (i == 4) ? 8'h13 : (i == 5) ? 8'h14 : 8'h18;
      h.cmd(i[2:0], v);
      rd(c, v * ((i < 2) ? 32'h6 : (i < 4) ? 32'hF0 : 32'h1));
    end
    h.cmd(3'h2, 32'h7);
    rd(8'h1A, 32'h690);
    $display("Command scaling test done");
    ENC_POSITION = $urandom;
    sp = $urandom;
    SET_POS_VALUE = sp;
    SET_POS_STB = 1'b1;
    @(negedge MCLK);
    SET_POS_STB = 1'b0;
    SET_POS_VALUE = ~sp;
    rd(8'h15, ENC_POSITION - sp);
    ENC_POSITION = ENC_POSITION + 32'h100;
    rd(8'h15, ENC_POSITION - sp);
    $display("Position offset test done");
    h.load(8'h16, 32'h0);
    fl = 16'h0;
    for (i = 0; i < 16; i = i + 1)
    begin
      FLAG_EVENTS = 16'h1 << i;
      @(negedge MCLK);
      FLAG_EVENTS = 16'h0;
      fl = fl | ((16'h1 << i) & 16'hC7FF);
      rd(8'h16, {16'h0, fl});
    end
    h.load(8'h16, 32'h0);
    rd(8'h16, 32'h0);
    RST_N = 1'b0;
    @(negedge MCLK);
    RST_N = 1'b1;
    rd(8'h11, 32'h1);
    $display("Flag and second reset test done");
    print_verdict;
  end
endmodule
